// ==== rtl/valve_pkg.sv ====
// Purpose: constants for the two-position valve actuator motor logic
// Assumes: 50 MHz sys_clk
// Notes: times in ms (debounce window in us), cycle counts derived
// Notes on behaviour
// [R01] single mode: b closed holds position a
// [R02] single mode: a contact ignored entirely
// [R03] jumper 1 fitted selects dual mode
// [R04] jumpers sampled only at power-up
// [R05] dual mode: a held 50 ms moves a
// [R06] dual mode: b closure moves to b
// [R07] dual mode: both or neither, no move
// [R08] position outputs high on arrival
// [R09] only moves to opposite position accepted
// [R10] jumpers 2,3 plus gearbox pick angle
// [R11] gearbox type sensed, no configuration input
// [R12] jumper 4 left empty by installer
// [R13] baud restore jumpers give 9600 default
// [R14] move time set by gearbox and ports
// [R15] contact inputs synchronised and debounced
package valve_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned HOLD_A_MS     = 50;
  localparam int unsigned HOLD_A_CYC    = HOLD_A_MS * (CLK_HZ / 1000);
  // short window: chatter of dry contacts dies well within, response stays quick
  localparam int unsigned DEBOUNCE_US   = 500;
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MS_CYC        = CLK_HZ / 1000;
  localparam logic [17:0] DEFAULT_BAUD  = 18'h2580;   // 9600 baud
  // move times, single stage 4/6/8/10 then dual stage 6/8/10/12 ports
  localparam logic [8:0] MOVE_S4_MS  = 9'h09b;   // 155 ms
  localparam logic [8:0] MOVE_S6_MS  = 9'h076;   // 118 ms
  localparam logic [8:0] MOVE_S8_MS  = 9'h068;   // 104 ms
  localparam logic [8:0] MOVE_S10_MS = 9'h05b;   // 91 ms
  localparam logic [8:0] MOVE_D6_MS  = 9'h15b;   // 347 ms
  localparam logic [8:0] MOVE_D8_MS  = 9'h133;   // 307 ms
  localparam logic [8:0] MOVE_D10_MS = 9'h117;   // 279 ms
  localparam logic [8:0] MOVE_D12_MS = 9'h0e7;   // 231 ms
  // port count codes
  localparam logic [3:0] PORTS_4  = 4'h4;
  localparam logic [3:0] PORTS_6  = 4'h6;
  localparam logic [3:0] PORTS_8  = 4'h8;
  localparam logic [3:0] PORTS_10 = 4'ha;
  localparam logic [3:0] PORTS_12 = 4'hc;
  typedef enum logic {POS_A, POS_B} pos_t;
endpackage

// ==== rtl/contact_debounce.sv ====
// Purpose: synchronise and debounce one contact closure input
// Assumes: closed contact reads as 1
// Notes: output changes only after input stable for the full window
`timescale 1ns/1ps
module contact_debounce
  import valve_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // contact
  input  wire logic raw,
  output logic      clean
);
  logic        sync1;   // first stage, read only by sync2
  logic        sync2;   // settled sample
  logic [18:0] cnt;     // stability counter
  logic [18:0] next_cnt;
  logic        next_clean;

  // compare settled sample with output, count while they differ
  always_comb begin
    next_cnt   = 19'h0;
    next_clean = clean;
    if (sync2 != clean) begin
      if (cnt == 19'(DEBOUNCE_CYC - 1)) begin
        next_clean = sync2; // [R15]
      end else begin
        next_cnt = cnt + 19'h1;
      end
    end
  end

  // two flop synchroniser plus state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      cnt   <= 19'h0;
      clean <= 1'b0;
    end else begin
      sync1 <= raw; // [R15]
      sync2 <= sync1;
      cnt   <= next_cnt;
      clean <= next_clean;
    end
  end
endmodule

// ==== rtl/valve_actuator_contact_control.sv ====
// Purpose: contact-closure motor control for a two-position valve actuator
// Assumes: rstn release marks power-up; inputs synchronous except contacts
// Notes: motor_run with motor_dir drives the motor for the timed move
`timescale 1ns/1ps
module valve_actuator_contact_control
  import valve_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // contact inputs on the control connector, 1 = closed to common
  input  wire logic       a_contact,
  input  wire logic       b_contact,
  // jumpers, 1 = fitted
  input  wire logic [4:1] jumper,
  input  wire logic       baud_restore_jumper,
  // gearbox sense, 1 = dual stage
  input  wire logic       gearbox_dual_sense,
  // position outputs
  output logic            pos_a_out,
  output logic            pos_b_out,
  // motor drive
  output logic            motor_run,
  output logic            motor_dir_to_a,
  // configuration seen
  output logic            dual_mode,
  output logic [3:0]      port_count,
  output logic            gearbox_dual,
  output logic            baud_default_load,
  output logic [17:0]     baud_rate
);
  typedef enum logic [1:0] {ST_CAPTURE, ST_IDLE, ST_MOVE} state_t;

  // ms per move from stage and jumpers 2,3
  function automatic logic [8:0] move_ms(input logic dual, input logic [1:0] j23);
    logic [8:0] r;
    r = MOVE_S6_MS;
    unique case ({dual, j23})
      3'b011:  r = MOVE_S4_MS;
      3'b000:  r = MOVE_S6_MS;
      3'b001:  r = MOVE_S8_MS;
      3'b010:  r = MOVE_S10_MS;
      3'b111:  r = MOVE_D6_MS;
      3'b100:  r = MOVE_D8_MS;
      3'b101:  r = MOVE_D10_MS;
      3'b110:  r = MOVE_D12_MS;
      default: r = MOVE_S6_MS;
    endcase
    return r;
  endfunction

  // port count from stage and jumpers 2,3 (j23 = {jumper3, jumper2})
  function automatic logic [3:0] ports_of(input logic dual, input logic [1:0] j23);
    logic [3:0] r;
    r = PORTS_6;
    unique case ({dual, j23})
      3'b011:  r = PORTS_4;
      3'b000:  r = PORTS_6;
      3'b001:  r = PORTS_8;
      3'b010:  r = PORTS_10;
      3'b111:  r = PORTS_6;
      3'b100:  r = PORTS_8;
      3'b101:  r = PORTS_10;
      3'b110:  r = PORTS_12;
      default: r = PORTS_6;
    endcase
    return r;
  endfunction

  logic       a_clean;   // debounced a contact
  logic       b_clean;   // debounced b contact

  contact_debounce u_deb_a (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .raw     (a_contact),
    .clean   (a_clean)
  );
  contact_debounce u_deb_b (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .raw     (b_contact),
    .clean   (b_clean)
  );

  state_t      state;        // control state
  pos_t        cur_pos;      // last reached position
  pos_t        target;       // position being moved to
  logic [8:0]  ms_total;     // latched move time
  logic [8:0]  ms_left;      // ms remaining in move
  logic [15:0] tick_cnt;     // 1 ms divider
  logic [21:0] hold_cnt;     // a contact hold timer
  logic        a_armed;      // a hold reached, awaiting action
  logic        arrived;      // position valid

  state_t      next_state;
  pos_t        next_cur_pos;
  pos_t        next_target;
  logic [8:0]  next_ms_total;
  logic [8:0]  next_ms_left;
  logic [15:0] next_tick_cnt;
  logic [21:0] next_hold_cnt;
  logic        next_a_armed;
  logic        next_arrived;
  logic        next_dual_mode;
  logic [3:0]  next_port_count;
  logic        next_gearbox_dual;
  logic        next_baud_load;
  logic [17:0] next_baud_rate;
  logic        ms_tick;      // one-cycle 1 ms enable
  logic        want;         // a move is requested
  pos_t        want_pos;     // requested position

  // request decode from debounced contacts and latched mode
  always_comb begin
    want     = 1'b0;
    want_pos = cur_pos;
    if (!dual_mode) begin
      want     = 1'b1;                      // [R02]
      want_pos = b_clean ? POS_A : POS_B;   // [R01]
    end else if (a_clean && !b_clean && a_armed) begin
      want     = 1'b1;                      // [R05]
      want_pos = POS_A;
    end else if (b_clean && !a_clean) begin
      want     = 1'b1;                      // [R06]
      want_pos = POS_B;
    end                                     // [R07]
  end

  assign ms_tick = (tick_cnt == 16'(MS_CYC - 1));

  // control next-state logic
  always_comb begin
    next_state        = state;
    next_cur_pos      = cur_pos;
    next_target       = target;
    next_ms_total     = ms_total;
    next_ms_left      = ms_left;
    next_tick_cnt     = ms_tick ? 16'h0 : tick_cnt + 16'h1;
    next_arrived      = arrived;
    next_dual_mode    = dual_mode;
    next_port_count   = port_count;
    next_gearbox_dual = gearbox_dual;
    next_baud_load    = 1'b0;
    next_baud_rate    = baud_rate;
    // hold timer only counts an exclusive a closure
    next_hold_cnt     = (a_clean && !b_clean) ? hold_cnt : 22'h0;
    next_a_armed      = a_armed && a_clean && !b_clean;
    if (a_clean && !b_clean && !a_armed) begin
      if (hold_cnt == 22'(HOLD_A_CYC - 1)) begin
        next_a_armed = 1'b1;              // [R05]
      end else begin
        next_hold_cnt = hold_cnt + 22'h1;
      end
    end
    unique case (state)
      ST_CAPTURE: begin
        // one-time capture after power-up release
        next_dual_mode    = jumper[1];                            // [R03] [R04]
        next_gearbox_dual = gearbox_dual_sense;                   // [R11]
        next_port_count   = ports_of(gearbox_dual_sense, jumper[3:2]); // [R10]
        next_ms_total     = move_ms(gearbox_dual_sense, jumper[3:2]);  // [R14]
        // jumper 4 is expected empty; restore pattern needs 3 and 4 off
        if (baud_restore_jumper && !jumper[3] && !jumper[4]) begin
          next_baud_rate = DEFAULT_BAUD;                          // [R13]
          next_baud_load = 1'b1;
        end
        next_arrived = 1'b1;
        next_state   = ST_IDLE;
      end
      ST_IDLE: begin
        // only the opposite position starts a move
        if (want && want_pos != cur_pos) begin                    // [R09]
          next_target   = want_pos;
          next_ms_left  = ms_total;
          next_tick_cnt = 16'h0;
          next_arrived  = 1'b0;
          next_a_armed  = 1'b0;
          next_state    = ST_MOVE;
        end
      end
      ST_MOVE: begin
        if (ms_tick) begin
          if (ms_left == 9'h1) begin
            next_cur_pos = target;                                // [R14]
            next_arrived = 1'b1;
            next_state   = ST_IDLE;
          end else begin
            next_ms_left = ms_left - 9'h1;
          end
        end
      end
    endcase
  end

  // control registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state        <= ST_CAPTURE;
      cur_pos      <= POS_B;
      target       <= POS_B;
      ms_total     <= MOVE_S6_MS;
      ms_left      <= 9'h0;
      tick_cnt     <= 16'h0;
      hold_cnt     <= 22'h0;
      a_armed      <= 1'b0;
      arrived      <= 1'b0;
      dual_mode    <= 1'b0;
      port_count   <= PORTS_6;
      gearbox_dual <= 1'b0;
      baud_default_load <= 1'b0;
      baud_rate    <= DEFAULT_BAUD;
    end else begin
      state        <= next_state;
      cur_pos      <= next_cur_pos;
      target       <= next_target;
      ms_total     <= next_ms_total;
      ms_left      <= next_ms_left;
      tick_cnt     <= next_tick_cnt;
      hold_cnt     <= next_hold_cnt;
      a_armed      <= next_a_armed;
      arrived      <= next_arrived;
      dual_mode    <= next_dual_mode;
      port_count   <= next_port_count;
      gearbox_dual <= next_gearbox_dual;
      baud_default_load <= next_baud_load;
      baud_rate    <= next_baud_rate;
    end
  end

  // registered position and motor outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pos_a_out      <= 1'b0;
      pos_b_out      <= 1'b0;
      motor_run      <= 1'b0;
      motor_dir_to_a <= 1'b0;
    end else begin
      pos_a_out      <= next_arrived && next_cur_pos == POS_A; // [R08]
      pos_b_out      <= next_arrived && next_cur_pos == POS_B; // [R08]
      motor_run      <= next_state == ST_MOVE;
      motor_dir_to_a <= next_target == POS_A;
    end
  end
endmodule

// ==== sim/valve_monitor.sv ====
// Purpose: port checker for the valve contact control
// Assumes: release of rstn is power-up
// Notes: config is judged against the jumpers seen at power-up
`timescale 1ns/1ps
module valve_monitor
  import valve_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rstn,
  // configuration
  input wire logic [4:1]  jumper,
  input wire logic        baud_restore_jumper,
  input wire logic        gearbox_dual_sense,
  input wire logic        dual_mode,
  input wire logic [3:0]  port_count,
  input wire logic        gearbox_dual,
  input wire logic        baud_default_load,
  input wire logic [17:0] baud_rate,
  // motion
  input wire logic        pos_a_out,
  input wire logic        pos_b_out,
  input wire logic        motor_run,
  input wire logic        motor_dir_to_a
);
  logic [1:0]  up, next_up;     // edges since power-up, saturating
  logic [4:1]  cj, next_cj;     // jumpers at power-up
  logic        cg, next_cg;     // gearbox sense at power-up
  logic        cb, next_cb;     // restore jumper at power-up
  logic [24:0] run, next_run;   // cycles of the current move
  int          ms;              // expected move time
  // expected angle; dual stage shifts every pattern one size up
  function automatic logic [3:0] ports(input logic [3:2] j, input logic g);
    case (j)
      2'b11:   return g ? PORTS_6 : PORTS_4;
      2'b00:   return g ? PORTS_8 : PORTS_6;
      2'b01:   return g ? PORTS_10 : PORTS_8;
      default: return g ? PORTS_12 : PORTS_10;
    endcase
  endfunction
  // move time for the decoded angle
  always_comb begin
    case (port_count)
      PORTS_4:  ms = int'(MOVE_S4_MS);
      PORTS_6:  ms = int'(gearbox_dual ? MOVE_D6_MS : MOVE_S6_MS);
      PORTS_8:  ms = int'(gearbox_dual ? MOVE_D8_MS : MOVE_S8_MS);
      PORTS_10: ms = int'(gearbox_dual ? MOVE_D10_MS : MOVE_S10_MS);
      default:  ms = int'(MOVE_D12_MS);
    endcase
  end
  // capture only on the first edge, as the block does
  always_comb begin
    next_up  = (up == 2'h3) ? up : up + 2'h1;
    next_cj  = (up == 2'h0) ? jumper : cj;
    next_cg  = (up == 2'h0) ? gearbox_dual_sense : cg;
    next_cb  = (up == 2'h0) ? baud_restore_jumper : cb;
    next_run = motor_run ? run + 25'h1 : 25'h0;
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      up  <= 2'h0;
      cj  <= 4'h0;
      cg  <= 1'b0;
      cb  <= 1'b0;
      run <= 25'h0;
    end else begin
      up  <= next_up;
      cj  <= next_cj;
      cg  <= next_cg;
      cb  <= next_cb;
      run <= next_run;
    end
  end
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  pos_one_hot_a: assert property (!(pos_a_out && pos_b_out))
    else $error("both position outputs high");
  move_pos_low_a: assert property (motor_run |-> !pos_a_out && !pos_b_out)
    else $error("position output high while moving");
  arrive_pos_a: assert property ($fell(motor_run) |-> pos_a_out == $past(motor_dir_to_a))
    else $error("wrong position output on arrival");
  move_opposite_a: assert property ($rose(motor_run) |->
    motor_dir_to_a == $past(pos_b_out) && ($past(pos_a_out) || $past(pos_b_out)))
    else $error("move not toward the opposite position");
  move_time_a: assert property ($fell(motor_run) |->
    int'(run) >= (ms - 1) * int'(MS_CYC) && int'(run) <= (ms + 1) * int'(MS_CYC))
    else $error("move time off");
  mode_jumper_a: assert property (up >= 2'h2 |-> dual_mode == cj[1])
    else $error("mode does not follow jumper 1");
  angle_decode_a: assert property (up >= 2'h2 |-> port_count == ports(cj[3:2], cg))
    else $error("port count decode wrong");
  gearbox_seen_a: assert property (up >= 2'h2 |-> gearbox_dual == cg)
    else $error("gearbox type not sensed");
  cfg_hold_a: assert property (up == 2'h3 |-> $stable(port_count) && $stable(dual_mode))
    else $error("config changed after power-up");
  // the restore pulse stands on the second edge after release, while up reads 1
  baud_load_a: assert property (up == 2'h1 |-> baud_default_load == (cb && cj[4:3] == 2'b00))
    else $error("baud restore pulse wrong");
  baud_once_a: assert property (baud_default_load |-> up == 2'h1 ##1 !baud_default_load)
    else $error("baud restore outside power-up");
  baud_rate_a: assert property (baud_rate == 18'h2580)
    else $error("baud rate not default");
  baud_c: cover property (baud_default_load);
  move_c: cover property ($rose(motor_run));
  dual_c: cover property (up == 2'h2 && dual_mode);
  twelve_c: cover property (up == 2'h2 && port_count == PORTS_12);
endmodule
bind valve_actuator_contact_control valve_monitor u_mon (.sys_clk(sys_clk), .rstn(rstn),
  .jumper(jumper), .baud_restore_jumper(baud_restore_jumper),
  .gearbox_dual_sense(gearbox_dual_sense), .dual_mode(dual_mode), .port_count(port_count),
  .gearbox_dual(gearbox_dual), .baud_default_load(baud_default_load), .baud_rate(baud_rate),
  .pos_a_out(pos_a_out), .pos_b_out(pos_b_out), .motor_run(motor_run),
  .motor_dir_to_a(motor_dir_to_a));

// ==== sim/host_model.sv ====
// Purpose: host instrument driving the contact closures
// Assumes: 1 = contact closed to common
// Notes: dry contacts, so only levels matter
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic sys_clk,
  // contacts
  output logic     a_contact,
  output logic     b_contact
);
  initial begin
    a_contact = 1'b0;
    b_contact = 1'b0;
  end
  // open both first when the closure flips sides
  // levels stand until the next call, so a closure is held as long as wanted
  task automatic drive(input logic a, input logic b);
    if ((a && b_contact) || (b && a_contact)) begin
      @(posedge sys_clk);
      a_contact <= 1'b0;
      b_contact <= 1'b0;
    end
    @(posedge sys_clk);
    a_contact <= a;
    b_contact <= b;
  endtask
  // chatter on b, far shorter than any debounce window
  task automatic bounce(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      b_contact <= ~b_contact;
    end
    @(posedge sys_clk);
    b_contact <= 1'b0;
  endtask
endmodule

// ==== sim/valve_actuator_contact_control_tb.sv ====
// Purpose: directed bench for the valve contact control
// Assumes: host model drives the contacts
// Notes: full moves take 91 to 347 ms, so moves are started but never run to arrival
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module valve_actuator_contact_control_tb;
  import valve_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [4:1]  jumper = 4'h0;
  logic        baud_restore_jumper = 1'b0;
  logic        gearbox_dual_sense = 1'b0;
  logic        a_contact, b_contact, pos_a_out, pos_b_out, motor_run, motor_dir_to_a;
  logic        dual_mode, gearbox_dual, baud_default_load;
  logic [3:0]  port_count;
  logic [17:0] baud_rate;
  int          error_cnt = 0;
  int          checked = 0;
  always #10 sys_clk = ~sys_clk;
  host_model HOST (.sys_clk(sys_clk), .a_contact(a_contact), .b_contact(b_contact));
  valve_actuator_contact_control DUT (.sys_clk(sys_clk), .rstn(rstn), .a_contact(a_contact),
    .b_contact(b_contact), .jumper(jumper), .baud_restore_jumper(baud_restore_jumper),
    .gearbox_dual_sense(gearbox_dual_sense), .pos_a_out(pos_a_out), .pos_b_out(pos_b_out),
    .motor_run(motor_run), .motor_dir_to_a(motor_dir_to_a), .dual_mode(dual_mode),
    .port_count(port_count), .gearbox_dual(gearbox_dual),
    .baud_default_load(baud_default_load), .baud_rate(baud_rate));
  task automatic end_sim();
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // power cycle with new jumpers, counting restore pulses
  task automatic power_up(input logic [4:1] j, input logic b, input logic g, output int n);
    n = 0;
    @(posedge sys_clk);
    rstn <= 1'b0;
    jumper <= j;
    baud_restore_jumper <= b;
    gearbox_dual_sense <= g;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (6) begin
      @(posedge sys_clk);
      #1 if (baud_default_load === 1'b1) n++;
    end
  endtask
  // every angle pattern on both gearboxes, jumper 4 kept empty
  task automatic t_config();
    logic [3:0] exp [8] = '{PORTS_6, PORTS_8, PORTS_10, PORTS_4,
                            PORTS_8, PORTS_10, PORTS_12, PORTS_6};
    int n;
    for (int i = 0; i < 8; i++) begin
      power_up({1'b0, i[1], i[0], i[0]}, 1'b0, i[2], n);
      `CHK("port_count", exp[i], port_count)
      `CHK("gearbox_dual", i[2], gearbox_dual)
      `CHK("dual_mode", i[0], dual_mode)
      `CHK("pos_b_out", 1'b1, pos_b_out)
      `CHK("pos_a_out", 1'b0, pos_a_out)
      `CHK("baud_pulse", 0, n)
    end
  endtask
  // restore only with jumpers 3 and 4 both out
  task automatic t_baud();
    int n;
    power_up(4'h3, 1'b1, 1'b0, n);
    `CHK("baud_pulse", 1, n)
    `CHK("baud_rate", 18'h2580, baud_rate)
    power_up(4'h4, 1'b1, 1'b0, n);
    `CHK("baud_pulse", 0, n)
  endtask
  // jumper moves while powered are not seen
  task automatic t_latch();
    int n;
    power_up(4'h0, 1'b0, 1'b0, n);
    @(posedge sys_clk);
    jumper <= 4'h7;
    gearbox_dual_sense <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 `CHK("port_count", PORTS_6, port_count)
    `CHK("dual_mode", 1'b0, dual_mode)
    `CHK("gearbox_dual", 1'b0, gearbox_dual)
  endtask
  // chatter on b and a closure on a must not start a move
  task automatic t_bounce();
    int n = 0;
    HOST.bounce(1000);
    HOST.drive(1'b1, 1'b0);
    repeat (5000) begin
      @(posedge sys_clk);
      #1 if (motor_run !== 1'b0) n++;
    end
    `CHK("motor_run", 0, n)
    HOST.drive(1'b0, 1'b0);
  endtask
  // single mode: b closed starts a move toward a, a closed as well changes nothing
  task automatic t_single();
    int n;
    int k;
    power_up(4'h0, 1'b0, 1'b0, n);
    HOST.drive(1'b1, 1'b1);
    k = 0;
    while (motor_run !== 1'b1 && k < DEBOUNCE_CYC + 100) begin
      @(posedge sys_clk);
      #1 k++;
    end
    `CHK("move_started", 1'b1, motor_run)
    `CHK("move_after_debounce", 1'b1, k >= DEBOUNCE_CYC)
    `CHK("motor_dir_to_a", 1'b1, motor_dir_to_a)
    `CHK("pos_b_out", 1'b0, pos_b_out)
    `CHK("pos_a_out", 1'b0, pos_a_out)
    if (motor_run !== 1'b1) end_sim();
  endtask
  // dual mode: both closed gives no move, nor b alone while already at b
  task automatic t_dual();
    int n;
    int k = 0;
    power_up(4'h1, 1'b0, 1'b0, n);
    repeat (DEBOUNCE_CYC + 100) begin
      @(posedge sys_clk);
      #1 if (motor_run !== 1'b0) k++;
    end
    `CHK("both_closed_run", 0, k)
    HOST.drive(1'b0, 1'b1);
    repeat (DEBOUNCE_CYC + 100) begin
      @(posedge sys_clk);
      #1 if (motor_run !== 1'b0) k++;
    end
    `CHK("b_at_b_run", 0, k)
  endtask
  initial begin
    t_config();
    t_baud();
    t_latch();
    t_bounce();
    t_single();
    t_dual();
    end_sim();
  end
endmodule
